// ---- seq_pkg.sv ----
// Package for the four-channel sample sequencer: widths, timing, states, carriers.
// Assumes nothing beyond a SystemVerilog compiler.
package seq_pkg;
  localparam int DATA_W = 12;
  localparam int CHAN_N = 4;
  localparam int PTR_W = 2;
  localparam int APPROX_W = 4;
  localparam int CLK_MHZ = 100;
  // Conversion clock at 2.5 MHz from 100 MHz
  localparam real CONV_CLK_MHZ = 2.5;
  localparam int CONV_DIV = int'(CLK_MHZ / CONV_CLK_MHZ);
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 6'h00;
  // Conversion-clock edges per channel and setup edges before channel 1
  localparam int EDGES_PER_CHAN = 19;
  localparam int SETUP_EDGES = 2;
  localparam int TOTAL_EDGES = SETUP_EDGES + CHAN_N * EDGES_PER_CHAN;
  localparam int SEQ_MAX_US_X10 = 325;
  localparam int CYC_W = 5;
  localparam logic [CYC_W-1:0] BIT_LAST = CYC_W'(DATA_W - 1);
  localparam logic [CYC_W-1:0] CHAN_TAIL = CYC_W'(EDGES_PER_CHAN - 1);
  localparam logic [CYC_W-1:0] SETUP_LAST = CYC_W'(SETUP_EDGES - 1);
  localparam logic [CYC_W-1:0] CYC_ZERO = 5'h00;
  localparam logic [PTR_W-1:0] PTR_FIRST = 2'h0;
  localparam logic [PTR_W-1:0] PTR_LAST = 2'h3;
  localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;
  localparam logic [DATA_W-1:0] TRIAL_TOP = 12'h800;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_CONV = 4'h4,
    ST_DONE = 4'h8
  } seq_state_type;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic start;
  } host_pins_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] oe;
  } bus_drive_type;
endpackage

// ---- approximation_register.sv ----
// Successive-approximation register: 12 trial steps, MSB first.
// Assumes a comparator answer each step, on the same clock.
`timescale 1ns/1ps
`default_nettype none
module approximation_register
  import seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic step,
  input wire logic comp_high,
  output logic [DATA_W-1:0] trial,
  output logic [DATA_W-1:0] result
);
  logic [DATA_W-1:0] trial_q;
  logic [DATA_W-1:0] mask_q;
  logic [DATA_W-1:0] keep;

  // Drop the trial bit when the held input lies below the trial level
  assign keep = comp_high ? trial_q : (trial_q & ~mask_q);
  assign trial = trial_q;
  assign result = keep;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trial_q <= DATA_ZERO;
      mask_q <= DATA_ZERO;
    end else if (load) begin
      trial_q <= TRIAL_TOP;
      mask_q <= TRIAL_TOP;
    end else if (step) begin
      trial_q <= keep | (mask_q >> 1);
      mask_q <= mask_q >> 1;
    end
  end
endmodule
`default_nettype wire

// ---- four_channel_sample_sequencer.sv ----
// Sequencing and readout of a four-channel simultaneous-sampling 12-bit converter.
// Assumes an analog front end that answers comparator queries per channel.
//
// Notes on behaviour
// R1: Results are 12-bit two's complement, three-state.
// R2: Sample-start rising edge begins a cycle.
// R3: Same edge holds all four track/holds.
// R4: Channels converted in order 1 to 4.
// R5: Each result stored in own register.
// R6: Done low only after all four stored.
// R7: Sequence takes 78 or 79 conversion edges.
// R8: 2.5 MHz clock finishes within 32.5 us.
// R9: Four reads return channels 1 to 4.
// R10: No way to pick a register directly.
// R11: First read falling strobe raises done.
// R12: Sample-start rise resets read pointer.
// R13: Drive bus only with select and strobe low.
// R14: External or internal conversion clock.
// R15: Bus released otherwise; extra reads ignored.
// R16: Sample-start synchronised before sequencing.
`timescale 1ns/1ps
`default_nettype none
module four_channel_sample_sequencer
  import seq_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SAMPLE_START,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic EXT_CLK,
  input wire logic EXT_CLK_TIED_LOW,
  input wire logic COMP_HIGH,
  output logic [PTR_W-1:0] COMP_CHANNEL,
  output logic [DATA_W-1:0] DAC_TRIAL,
  output logic [CHAN_N-1:0] HOLD,
  output logic DONE_N,
  output logic [DATA_W-1:0] RESULT_BUS_O,
  output logic [DATA_W-1:0] RESULT_BUS_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  host_pins_type pins_meta_q;
  host_pins_type pins_q;
  host_pins_type pins_old_q;
  logic [1:0] clk_meta_q;
  logic [1:0] clk_q;
  logic ext_clk_old_q;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta_q <= '{cs_n: 1'b1, rd_n: 1'b1, start: 1'b0};
      pins_q <= '{cs_n: 1'b1, rd_n: 1'b1, start: 1'b0};
      pins_old_q <= '{cs_n: 1'b1, rd_n: 1'b1, start: 1'b0};
      clk_meta_q <= 2'h0;
      clk_q <= 2'h0;
      ext_clk_old_q <= 1'b0;
    end else begin
      pins_meta_q <= '{cs_n: CS_N, rd_n: RD_N, start: SAMPLE_START}; // R16
      pins_q <= pins_meta_q;
      pins_old_q <= pins_q;
      clk_meta_q <= {EXT_CLK_TIED_LOW, EXT_CLK};
      clk_q <= clk_meta_q;
      ext_clk_old_q <= clk_q[0];
    end
  end

  logic start_rise;
  logic rd_fall;
  logic rd_rise;
  logic selected;
  assign start_rise = pins_q.start & ~pins_old_q.start; // R2
  assign selected = ~pins_q.cs_n;
  assign rd_fall = selected & ~pins_q.rd_n & pins_old_q.rd_n;
  assign rd_rise = ~pins_old_q.cs_n & pins_q.rd_n & ~pins_old_q.rd_n;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock: external edge or internal divider
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic int_tick;
  logic ext_tick;
  logic conv_tick;
  logic use_internal;
  assign use_internal = clk_q[1];
  assign int_tick = (div_q == DIV_LAST); // R8
  assign div_d = int_tick ? DIV_ZERO : div_q + 6'h01;
  assign ext_tick = clk_q[0] & ~ext_clk_old_q;
  assign conv_tick = use_internal ? int_tick : ext_tick; // R14

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= DIV_ZERO;
    end else begin
      div_q <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  seq_state_type state_q;
  seq_state_type state_d;
  logic [CYC_W-1:0] cyc_q;
  logic [CYC_W-1:0] cyc_d;
  logic [PTR_W-1:0] chan_q;
  logic [PTR_W-1:0] chan_d;
  logic start_pend_q;
  logic in_setup;
  logic in_conv;
  logic approx_load;
  logic approx_step;
  logic store;
  logic chan_end;
  logic last_chan;
  logic seq_end;
  logic [DATA_W-1:0] approx_trial;
  logic [DATA_W-1:0] approx_result;

  assign in_setup = (state_q == ST_SETUP);
  assign in_conv = (state_q == ST_CONV);
  assign last_chan = (chan_q == PTR_LAST);
  // Start edge waits for the next conversion edge, giving 78 or 79 edges
  assign chan_end = conv_tick & (cyc_q == CHAN_TAIL);
  assign store = in_conv & conv_tick & (cyc_q == BIT_LAST); // R5
  assign approx_step = in_conv & conv_tick & (cyc_q < BIT_LAST);
  assign approx_load = (in_setup & conv_tick & (cyc_q == SETUP_LAST))
    | (in_conv & chan_end & ~last_chan);
  // Last tick of channel 4 ends the sequence
  assign seq_end = in_conv & chan_end & last_chan; // R6 R7

  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    chan_d = chan_q;
    case (state_q)
      ST_IDLE, ST_DONE: begin
        if (start_pend_q && conv_tick) begin // R7
          state_d = ST_SETUP;
          cyc_d = CYC_ZERO;
          chan_d = PTR_FIRST;
        end
      end
      ST_SETUP: begin
        if (conv_tick) begin
          cyc_d = cyc_q + 5'h01;
          if (cyc_q == SETUP_LAST) begin
            state_d = ST_CONV;
            cyc_d = CYC_ZERO;
          end
        end
      end
      ST_CONV: begin
        if (chan_end) begin
          cyc_d = CYC_ZERO;
          if (chan_q == PTR_LAST) begin
            state_d = ST_DONE; // R6
          end else begin
            chan_d = chan_q + 2'h1; // R4
          end
        end else if (conv_tick) begin
          cyc_d = cyc_q + 5'h01;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cyc_q <= CYC_ZERO;
      chan_q <= PTR_FIRST;
      start_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      chan_q <= chan_d;
      start_pend_q <= start_rise | (start_pend_q & ~conv_tick);
    end
  end

  approximation_register i_approximation_register (
    .clk(CLK),
    .rst_n(rst_n),
    .load(approx_load),
    .step(approx_step),
    .comp_high(COMP_HIGH),
    .trial(approx_trial),
    .result(approx_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result registers, track/hold control and done flag
  logic [DATA_W-1:0] result_mem [CHAN_N];
  logic holding_q;
  logic done_n_q;
  logic busy;
  logic [DATA_W-1:0] coded;
  assign busy = in_setup | in_conv;
  // Offset-binary trial word to two's complement: invert the top bit
  assign coded = approx_result ^ TRIAL_TOP; // R1

  generate
    for (genvar i = 0; i < CHAN_N; i++) begin : g_reg
      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          result_mem[i] <= DATA_ZERO;
        end else if (store && chan_q == PTR_W'(i)) begin
          result_mem[i] <= coded; // R5
        end
      end
    end
  endgenerate

  // Hold stands from the start edge to the end of channel 4, pending restart included
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      holding_q <= 1'b0;
    end else if (start_rise) begin
      holding_q <= 1'b1; // R3
    end else if (seq_end) begin
      holding_q <= 1'b0;
    end
  end

  // Sequence end wins over a read strobe in the same cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_n_q <= 1'b1;
    end else if (seq_end) begin
      done_n_q <= 1'b0; // R6
    end else if (rd_fall || start_rise) begin
      done_n_q <= 1'b1; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequential readout through implicit pointer
  logic [PTR_W-1:0] rd_ptr_q;
  logic reads_left_q;
  logic read_ok;
  logic drive;
  logic advance;
  logic last_read;
  bus_drive_type bus_q;
  bus_drive_type bus_d;

  assign read_ok = reads_left_q & ~busy; // R13
  assign drive = selected & ~pins_q.rd_n & read_ok; // R13
  assign bus_d.data = drive ? result_mem[rd_ptr_q] : DATA_ZERO; // R9 R10
  assign bus_d.oe = {DATA_W{drive}}; // R15

  // Pointer steps when a driven read ends; the fourth read closes the window
  assign advance = rd_rise & read_ok;
  assign last_read = advance & (rd_ptr_q == PTR_LAST);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= '{data: DATA_ZERO, oe: DATA_ZERO};
    end else begin
      bus_q <= bus_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_q <= PTR_FIRST;
    end else if (start_rise) begin
      rd_ptr_q <= PTR_FIRST; // R12
    end else if (advance) begin
      rd_ptr_q <= rd_ptr_q + 2'h1; // R9
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      reads_left_q <= 1'b0;
    end else if (start_rise) begin
      reads_left_q <= 1'b0;
    end else if (seq_end) begin
      reads_left_q <= 1'b1;
    end else if (last_read) begin
      reads_left_q <= 1'b0; // R15
    end
  end

  assign COMP_CHANNEL = chan_q;
  assign DAC_TRIAL = approx_trial;
  assign HOLD = {CHAN_N{holding_q}}; // R3
  assign DONE_N = done_n_q;
  assign RESULT_BUS_O = bus_q.data; // R1
  assign RESULT_BUS_OE = bus_q.oe;
endmodule
`default_nettype wire

// ---- seq_monitor.sv ----
// Checker on the sequencer top ports.
// Assumes it is bound into four_channel_sample_sequencer.
`timescale 1ns/1ps
`default_nettype none
module seq_monitor
  import seq_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SAMPLE_START,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic [PTR_W-1:0] COMP_CHANNEL,
  input wire logic [CHAN_N-1:0] HOLD,
  input wire logic DONE_N,
  input wire logic [DATA_W-1:0] RESULT_BUS_O,
  input wire logic [DATA_W-1:0] RESULT_BUS_OE
);
  logic [12:0] busy_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Cycles spent holding
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) busy_q <= 13'h0000;
    else busy_q <= HOLD[0] ? busy_q + 13'h0001 : 13'h0000;
  end
  oe_whole_a: assert property (RESULT_BUS_OE == '0 || RESULT_BUS_OE == '1)
    else $error("bus enable bits differ");
  hold_whole_a: assert property (HOLD == '0 || HOLD == '1)
    else $error("hold bits differ");
  start_holds_a: assert property ($rose(SAMPLE_START) && !HOLD[0] |-> ##[3:6] HOLD[0])
    else $error("start edge did not hold");
  chan_step_a: assert property (HOLD[0] && $past(HOLD[0]) && $changed(COMP_CHANNEL)
    |-> COMP_CHANNEL == $past(COMP_CHANNEL) + 2'h1) else $error("channel order broken");
  busy_drive_a: assert property (HOLD[0] |-> RESULT_BUS_OE == '0)
    else $error("bus driven during conversion");
  idle_float_a: assert property (RD_N [*5] |-> RESULT_BUS_OE == '0)
    else $error("bus driven without strobe");
  float_zero_a: assert property (RESULT_BUS_OE == '0 |-> RESULT_BUS_O == '0)
    else $error("data not zero while released");
  done_track_a: assert property ($fell(DONE_N) |-> ##[0:2] HOLD == '0)
    else $error("done without release of hold");
  conv_max_a: assert property (HOLD[0] |-> busy_q < 13'h0cb2)
    else $error("conversion too long");
  conv_min_a: assert property ($fell(DONE_N) |-> $past(busy_q) >= 13'h0bb8)
    else $error("conversion too short");
  done_clear_a: assert property (!DONE_N && !CS_N && $fell(RD_N) |-> ##[1:5] DONE_N)
    else $error("done not cleared by first read");
endmodule
bind four_channel_sample_sequencer seq_monitor i_seq_monitor (.CLK(CLK), .NRST(NRST),
  .SAMPLE_START(SAMPLE_START), .CS_N(CS_N), .RD_N(RD_N), .COMP_CHANNEL(COMP_CHANNEL),
  .HOLD(HOLD), .DONE_N(DONE_N), .RESULT_BUS_O(RESULT_BUS_O), .RESULT_BUS_OE(RESULT_BUS_OE));
`default_nettype wire

// ---- afe_model.sv ----
// Analog front end: four track/holds and a comparator.
// Assumes offset-binary levels in the trial word space.
`timescale 1ns/1ps
`default_nettype none
module afe_model
  import seq_pkg::*;
(
  input wire logic clk,
  input wire logic [CHAN_N-1:0][DATA_W-1:0] level,
  input wire logic [PTR_W-1:0] channel,
  input wire logic [DATA_W-1:0] trial,
  input wire logic [CHAN_N-1:0] hold,
  output logic comp_high
);
  logic [CHAN_N-1:0][DATA_W-1:0] held_q;
  // Track while released, freeze while holding
  always_ff @(posedge clk) begin
    for (int i = 0; i < CHAN_N; i++) begin
      if (!hold[i]) held_q[i] <= level[i];
    end
  end
  assign comp_high = held_q[channel] >= trial;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the sample sequencer.
// Assumes afe_model as analog side and seq_monitor bound in.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import seq_pkg::*;
;
  typedef logic [CHAN_N-1:0][DATA_W-1:0] lv_type;
  localparam lv_type VA = {12'h000, 12'hfff, 12'h800, 12'h0a5};
  localparam lv_type VB = {12'h123, 12'h456, 12'h789, 12'hf0e};
  logic clk = 1'b0, nrst = 1'b0, ext_clk = 1'b0, ext_run = 1'b0, tied = 1'b1, comp;
  host_pins_type pins = '{1'b1, 1'b1, 1'b0};
  lv_type level = '0;
  logic [PTR_W-1:0] ch;
  logic [DATA_W-1:0] trial, bus_o, bus_oe;
  logic [CHAN_N-1:0] hold;
  logic done_n;
  int n_errors = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  always #200 if (ext_run) ext_clk = ~ext_clk;
  four_channel_sample_sequencer i_four_channel_sample_sequencer (.CLK(clk), .NRST(nrst),
    .SAMPLE_START(pins.start), .CS_N(pins.cs_n), .RD_N(pins.rd_n), .EXT_CLK(ext_clk),
    .EXT_CLK_TIED_LOW(tied), .COMP_HIGH(comp), .COMP_CHANNEL(ch), .DAC_TRIAL(trial),
    .HOLD(hold), .DONE_N(done_n), .RESULT_BUS_O(bus_o), .RESULT_BUS_OE(bus_oe));
  afe_model i_afe_model (.clk(clk), .level(level), .channel(ch), .trial(trial),
    .hold(hold), .comp_high(comp));
  ////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd(output logic [DATA_W-1:0] d, output logic [DATA_W-1:0] oe);
    pins.cs_n = 1'b0;
    pins.rd_n = 1'b0;
    cyc(5);
    d = bus_o;
    oe = bus_oe;
    pins.cs_n = 1'b1;
    pins.rd_n = 1'b1;
    cyc(6);
  endtask
  task automatic conv(logic ext, lv_type v);
    logic [DATA_W-1:0] d, oe;
    int n;
    tied = !ext;
    ext_run = ext;
    level = v;
    pins.start = 1'b1;
    cyc(10);
    pins.start = 1'b0;
    level = ~v;
    rd(d, oe);
    chk("early enable", 12'h000, oe);
    n = 21;
    while (done_n !== 1'b0 && n < 4000) begin
      cyc(1);
      n++;
    end
    if (n >= 4000) begin
      n_errors++;
      results();
    end
    chk("conv cycles ok", 12'h001, 12'(n >= 3000 && n <= 3250));
    chk("hold after done", 12'h000, 12'(hold));
  endtask
  task automatic reads(lv_type v, int k);
    logic [DATA_W-1:0] d, oe;
    for (int i = 0; i < k; i++) begin
      rd(d, oe);
      if (i < CHAN_N) begin
        chk("result", v[i] ^ TRIAL_TOP, d);
        chk("enable", 12'hfff, oe);
        chk("done", 12'h001, 12'(done_n));
      end else begin
        chk("extra enable", 12'h000, oe);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic sc_reset();
    chk("done", 12'h001, 12'(done_n));
    chk("hold", 12'h000, 12'(hold));
    chk("enable", 12'h000, bus_oe);
    chk("data", DATA_ZERO, bus_o);
    chk("trial", DATA_ZERO, trial);
    chk("channel", DATA_ZERO, 12'(ch));
  endtask
  task automatic sc_full();
    conv(1'b0, VA);
    reads(VA, 5);
  endtask
  task automatic sc_ext();
    conv(1'b1, VB);
    reads(VB, 4);
  endtask
  task automatic sc_restart();
    conv(1'b0, VA);
    reads(VA, 2);
    conv(1'b0, VB);
    reads(VB, 1);
  endtask
  initial begin
    cyc(2);
    nrst = 1'b1;
    cyc(4);
    sc_reset();
    sc_full();
    sc_ext();
    sc_restart();
    results();
  end
endmodule
`default_nettype wire
